// file: rtl/mpr_top.sv
// Purpose: fan/pin, over-temperature and conversion rate configuration
// Assumes: register port driven by the serial interface on clk_i
// Notes:   converter, status and mask registers live elsewhere
//
// What this block does
// - bit 0 selects first tach level mode
// - bit 1 selects second tach level mode
// - divisor fields: 1, 2, 4, 8
// - level mode: code 01 active low
// - bits 7:6 = 01 routes overtemp output
// - bits 7:6 = 10 routes reset pulse
// - bits 7:6 = 11 disables shared pin
// - overtemp bit 0 read-only pin state, reads 1 unless the pin routes overtemp
// - overtemp bit 1 sets output polarity
// - overtemp bit 2 one-time versus comparator
// - overtemp bit 3 selects 11-bit resolution
// - bits 7:4 hold four result LSBs
// - 8-bit mode: bit 7 LSB only
// - delay is 1.42 ms times (8N+6)
// - rate bit 0 gives continuous conversion
// - fan/pin register resets to 14h
// - rate register at 07h resets 40h
// - reset command pulses pin, then clears
// - fan limit exceeded raises fan event in counting mode
`timescale 1ns/1ps
`include "mpr_consts.svh"
module mpr_top
   import mpr_pkg::*;
#(
   parameter int unsigned MON_UNIT_CYCLES =
      `MPR_MON_UNIT_NS / `MPR_CLK_PERIOD_NS,
   parameter int unsigned RST_PULSE_CYCLES =
      (`MPR_RST_PULSE_NS + `MPR_CLK_PERIOD_NS - 1) / `MPR_CLK_PERIOD_NS
)
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic [1:0] tach_input_i,
   input  wire logic [1:0] fan_limit_hit_i,
   output logic      [1:0] fan_count_pulse_o,
   output logic      [1:0] fan_event_o,
   input  wire logic       overtemp_hit_i,
   input  wire logic       temp_wr_i,
   input  wire logic [3:0] temp_frac_i,
   output logic            temp_hi_res_o,
   input  wire logic [7:0] rate_count_i,
   input  wire logic       conv_done_i,
   output logic            conv_start_o,
   input  wire logic       reset_cmd_i,
   output logic            reset_cmd_done_o,
   output logic            shared_alert_pin_o,
   output logic            shared_alert_pin_oe_n_o
);

   localparam int UNIT_W  = $clog2(MON_UNIT_CYCLES + 1);
   localparam int PULSE_W = $clog2(RST_PULSE_CYCLES + 1);

   if (MON_UNIT_CYCLES < 1 || RST_PULSE_CYCLES < 1)
   begin : g_bad_timing
      $error("mpr_top: timing counts must be at least one cycle");
   end

   // register file
   logic [7:0] fan_cfg_q;
   logic [7:0] fan_cfg_d;
   logic [2:0] os_ctl_q;
   logic [2:0] os_ctl_d;
   logic [3:0] frac_q;
   logic [3:0] frac_d;
   logic [7:0] rate_q;
   logic [7:0] rate_d;
   logic [7:0] rdata_d;
   logic       wr_fan;
   logic       wr_os;
   logic       wr_rate;
   logic       rd_os;

   assign wr_fan  = reg_wr_i && (reg_addr_i == `MPR_OFS_FANCFG);
   assign wr_os   = reg_wr_i && (reg_addr_i == `MPR_OFS_OSCFG);
   assign wr_rate = reg_wr_i && (reg_addr_i == `MPR_OFS_RATE);
   assign rd_os   = reg_rd_i && (reg_addr_i == `MPR_OFS_OSCFG);

   // pin routing
   mpr_pin_mode_t pin_mode;
   logic          os_active_q;
   logic          os_active_d;
   logic          hit_prev_q;
   logic          os_level;
   logic          pin_d;
   logic          pin_oe_n_d;
   logic          os_stat;

   always_comb
   begin
      unique case ({fan_cfg_q[`MPR_PIN_RST_BIT], fan_cfg_q[`MPR_PIN_OS_BIT]})
         2'b01:   pin_mode = MPR_PIN_OS;
         2'b10:   pin_mode = MPR_PIN_RST;
         default: pin_mode = MPR_PIN_OFF;
      endcase
   end

   always_comb
   begin
      fan_cfg_d = fan_cfg_q;
      os_ctl_d  = os_ctl_q;
      frac_d    = frac_q;
      rate_d    = rate_q;
      if (wr_fan)
      begin
         fan_cfg_d = reg_wdata_i;
      end
      if (wr_os)
      begin
         // bit 0 is status and ignores writes
         os_ctl_d = reg_wdata_i[`MPR_OS_RES_BIT:`MPR_OS_POL_BIT];
         frac_d   = reg_wdata_i[7:`MPR_OS_FRAC_LSB];
      end
      // a result landing in the write cycle wins over software
      if (temp_wr_i)
      begin
         if (os_ctl_q[`MPR_OS_RES_BIT - 1])
         begin
            frac_d = temp_frac_i;
         end
         else
         begin
            frac_d = {temp_frac_i[3], 3'h0};
         end
      end
      if (wr_rate)
      begin
         // reserved bits stored as written; software keeps them zero
         rate_d = reg_wdata_i;
      end
   end

   assign os_stat = (pin_mode == MPR_PIN_OS) ? shared_alert_pin_o : 1'b1;

   always_comb
   begin
      unique case (reg_addr_i)
         `MPR_OFS_FANCFG: rdata_d = fan_cfg_q;
         `MPR_OFS_OSCFG:  rdata_d = {frac_q, os_ctl_q, os_stat};
         `MPR_OFS_RATE:   rdata_d = rate_q;
         default:         rdata_d = 8'h00;
      endcase
      if (!reg_rd_i)
      begin
         rdata_d = reg_rdata_o;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         fan_cfg_q   <= `MPR_RST_FANCFG;
         os_ctl_q    <= 3'h0;
         frac_q      <= 4'h0;
         rate_q      <= `MPR_RST_RATE;
         reg_rdata_o <= 8'h00;
      end
      else
      begin
         fan_cfg_q   <= fan_cfg_d;
         os_ctl_q    <= os_ctl_d;
         frac_q      <= frac_d;
         rate_q      <= rate_d;
         reg_rdata_o <= rdata_d;
      end
   end

   assign temp_hi_res_o = os_ctl_q[`MPR_OS_RES_BIT - 1];

   // tachometer inputs
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_tach
         mpr_tach_in u_tach
         (
            .clk_i         (clk_i),
            .rst_i         (rst_i),
            .pin_i         (tach_input_i[g]),
            .level_mode_i  (fan_cfg_q[`MPR_FAN_MODE0_BIT + g]),
            .ctl_i         (fan_cfg_q[`MPR_FAN_DIV0_LSB + 2*g +: 2]),
            .limit_hit_i   (fan_limit_hit_i[g]),
            .count_pulse_o (fan_count_pulse_o[g]),
            .event_o       (fan_event_o[g])
         );
      end
   endgenerate

   // reset command pulse
   logic [PULSE_W-1:0] pulse_cnt_q;
   logic [PULSE_W-1:0] pulse_cnt_d;
   logic               pulse_on_q;
   logic               pulse_on_d;
   logic               cmd_done_q;
   logic               cmd_done_d;

   always_comb
   begin
      pulse_cnt_d = pulse_cnt_q;
      pulse_on_d  = pulse_on_q;
      cmd_done_d  = 1'b0;
      if (pulse_on_q)
      begin
         if (pulse_cnt_q == PULSE_W'(1))
         begin
            pulse_on_d = 1'b0;
            cmd_done_d = 1'b1;
         end
         else
         begin
            pulse_cnt_d = pulse_cnt_q - PULSE_W'(1);
         end
      end
      else if (reset_cmd_i && !cmd_done_q)
      begin
         if (pin_mode == MPR_PIN_RST)
         begin
            pulse_on_d  = 1'b1;
            pulse_cnt_d = PULSE_W'(RST_PULSE_CYCLES);
         end
         else
         begin
            // unrouted: no pulse, the command bit is released at once
            cmd_done_d = 1'b1;
         end
      end
   end

   assign reset_cmd_done_o = cmd_done_q;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pulse_cnt_q <= '0;
         pulse_on_q  <= 1'b0;
         cmd_done_q  <= 1'b0;
      end
      else
      begin
         pulse_cnt_q <= pulse_cnt_d;
         pulse_on_q  <= pulse_on_d;
         cmd_done_q  <= cmd_done_d;
      end
   end

   // over-temperature output and pin drive
   always_comb
   begin
      os_active_d = os_active_q;
      if (os_ctl_q[`MPR_OS_MODE_BIT - 1])
      begin
         // one-time: cleared by reading, a new hit wins over the read
         if (rd_os)
         begin
            os_active_d = 1'b0;
         end
         if (overtemp_hit_i && !hit_prev_q)
         begin
            os_active_d = 1'b1;
         end
      end
      else
      begin
         os_active_d = overtemp_hit_i;
      end
      os_level = os_ctl_q[`MPR_OS_POL_BIT - 1] ? os_active_q
                                               : !os_active_q;
      unique case (pin_mode)
         MPR_PIN_OS:
         begin
            pin_d      = os_level;
            pin_oe_n_d = 1'b0;
         end
         MPR_PIN_RST:
         begin
            // next state, so the pin releases on the edge that clears
            pin_d      = !pulse_on_d;
            pin_oe_n_d = 1'b0;
         end
         default:
         begin
            pin_d      = 1'b1;
            pin_oe_n_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         os_active_q             <= 1'b0;
         hit_prev_q              <= 1'b0;
         shared_alert_pin_o      <= 1'b1;
         shared_alert_pin_oe_n_o <= 1'b1;
      end
      else
      begin
         os_active_q             <= os_active_d;
         hit_prev_q              <= overtemp_hit_i;
         shared_alert_pin_o      <= pin_d;
         shared_alert_pin_oe_n_o <= pin_oe_n_d;
      end
   end

   // monitoring delay between conversion rounds
   mpr_timer_state_t   tstate_q;
   mpr_timer_state_t   tstate_d;
   logic [UNIT_W-1:0]  unit_q;
   logic [UNIT_W-1:0]  unit_d;
   logic [10:0]        units_q;
   logic [10:0]        units_d;
   logic               start_d;
   logic               continuous;

   assign continuous = rate_q[`MPR_RATE_CONT_BIT];

   always_comb
   begin
      tstate_d = tstate_q;
      unit_d   = unit_q;
      units_d  = units_q;
      start_d  = 1'b0;
      unique case (tstate_q)
         MPR_T_KICK:
         begin
            start_d  = 1'b1;
            tstate_d = MPR_T_BUSY;
         end
         MPR_T_BUSY:
         begin
            if (conv_done_i)
            begin
               if (continuous)
               begin
                  tstate_d = MPR_T_KICK;
               end
               else
               begin
                  units_d  = 11'(`MPR_MON_MUL * rate_count_i
                                 + `MPR_MON_ADD);
                  unit_d   = UNIT_W'(MON_UNIT_CYCLES);
                  tstate_d = MPR_T_WAIT;
               end
            end
         end
         MPR_T_WAIT:
         begin
            if (continuous)
            begin
               tstate_d = MPR_T_KICK;
            end
            else if (unit_q > UNIT_W'(1))
            begin
               unit_d = unit_q - UNIT_W'(1);
            end
            else if (units_q > 11'h001)
            begin
               units_d = units_q - 11'h001;
               unit_d  = UNIT_W'(MON_UNIT_CYCLES);
            end
            else
            begin
               tstate_d = MPR_T_KICK;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tstate_q     <= MPR_T_KICK;
         unit_q       <= '0;
         units_q      <= 11'h000;
         conv_start_o <= 1'b0;
      end
      else
      begin
         tstate_q     <= tstate_d;
         unit_q       <= unit_d;
         units_q      <= units_d;
         conv_start_o <= start_d;
      end
   end

endmodule

// file: rtl/mpr_consts.svh
// Purpose: offsets, field positions, reset values and timing of the block
// Assumes: 125 MHz system clock
// Notes:   included by the top module only
`ifndef MPR_CONSTS_SVH
`define MPR_CONSTS_SVH

`define MPR_OFS_FANCFG      8'h05
`define MPR_OFS_OSCFG       8'h06
`define MPR_OFS_RATE        8'h07

`define MPR_RST_FANCFG      8'h14
`define MPR_RST_OSCFG       8'h01
`define MPR_RST_RATE        8'h40

`define MPR_FAN_MODE0_BIT   0
`define MPR_FAN_MODE1_BIT   1
`define MPR_FAN_DIV0_LSB    2
`define MPR_FAN_DIV1_LSB    4
`define MPR_PIN_OS_BIT      6
`define MPR_PIN_RST_BIT     7

`define MPR_OS_STAT_BIT     0
`define MPR_OS_POL_BIT      1
`define MPR_OS_MODE_BIT     2
`define MPR_OS_RES_BIT      3
`define MPR_OS_FRAC_LSB     4

`define MPR_RATE_CONT_BIT   0

`define MPR_CLK_PERIOD_NS   8
`define MPR_MON_UNIT_NS     1420000
`define MPR_MON_MUL         8
`define MPR_MON_ADD         6
`define MPR_RST_PULSE_NS    20000

`endif

// file: rtl/mpr_pkg.sv
// Purpose: shared types of the monitor configuration block
// Assumes: constants come from mpr_consts.svh
// Notes:   types only
package mpr_pkg;

   typedef enum logic [1:0]
   {
      MPR_PIN_OFF = 2'b00,
      MPR_PIN_OS  = 2'b01,
      MPR_PIN_RST = 2'b10
   } mpr_pin_mode_t;

   typedef enum logic [1:0]
   {
      MPR_T_KICK = 2'b00,
      MPR_T_BUSY = 2'b01,
      MPR_T_WAIT = 2'b10
   } mpr_timer_state_t;

endpackage

// file: rtl/mpr_tach_in.sv
// Purpose: one tachometer input, counting or level-sensitive
// Assumes: pin is asynchronous to clk_i
// Notes:   divided pulse and event come straight from flops
`timescale 1ns/1ps
module mpr_tach_in
   import mpr_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       pin_i,
   input  wire logic       level_mode_i,
   input  wire logic [1:0] ctl_i,
   input  wire logic       limit_hit_i,
   output logic            count_pulse_o,
   output logic            event_o
);

   logic       sync1_q;
   logic       sync2_q;
   logic       prev_q;
   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   logic       pulse_d;
   logic       event_d;
   logic       active_low;
   logic [2:0] div_last;

   assign active_low = (ctl_i == 2'b01);
   assign div_last   = 3'((4'h1 << ctl_i) - 4'h1);

   always_comb
   begin
      cnt_d   = cnt_q;
      pulse_d = 1'b0;
      // divide rising edges by 1, 2, 4 or 8
      if (!level_mode_i && sync2_q && !prev_q)
      begin
         if (cnt_q >= div_last)
         begin
            cnt_d   = 3'h0;
            pulse_d = 1'b1;
         end
         else
         begin
            cnt_d = cnt_q + 3'h1;
         end
      end
      if (level_mode_i)
      begin
         cnt_d = 3'h0;
      end
      if (level_mode_i)
      begin
         event_d = active_low ? !sync2_q : sync2_q;
      end
      else
      begin
         event_d = limit_hit_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sync1_q       <= 1'b0;
         sync2_q       <= 1'b0;
         prev_q        <= 1'b0;
         cnt_q         <= 3'h0;
         count_pulse_o <= 1'b0;
         event_o       <= 1'b0;
      end
      else
      begin
         sync1_q       <= pin_i;
         sync2_q       <= sync1_q;
         prev_q        <= sync2_q;
         cnt_q         <= cnt_d;
         count_pulse_o <= pulse_d;
         event_o       <= event_d;
      end
   end

endmodule

// file: tb/mpr_top_properties.sv
// Purpose: port-level properties of mpr_top
// Assumes: pin and config bits shadowed from host writes
// Notes:   bind statement follows the module
`timescale 1ns/1ps
module mpr_top_properties
   import mpr_pkg::*;
#(
   parameter int unsigned MON_UNIT_CYCLES  = 4,
   parameter int unsigned RST_PULSE_CYCLES = 3
)
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       overtemp_hit_i,
   input wire logic [7:0] rate_count_i,
   input wire logic       conv_done_i,
   input wire logic       conv_start_o,
   input wire logic       reset_cmd_i,
   input wire logic       reset_cmd_done_o,
   input wire logic       shared_alert_pin_o,
   input wire logic       shared_alert_pin_oe_n_o
);
   // {pin route[1:0], one-time, polarity, continuous}
   logic [4:0]  cfg_q, cfg_d;
   logic [15:0] low_q, low_d;
   logic [31:0] gap_q, gap_d;
   logic        arm_q, arm_d;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   always_comb
   begin
      cfg_d = cfg_q;
      if (reg_wr_i && reg_addr_i == 8'h05)
         cfg_d[4:3] = reg_wdata_i[7:6];
      if (reg_wr_i && reg_addr_i == 8'h06)
         cfg_d[2:1] = reg_wdata_i[2:1];
      if (reg_wr_i && reg_addr_i == 8'h07)
         cfg_d[0] = reg_wdata_i[0];
      low_d = shared_alert_pin_o ? 16'h0000 : low_q + 16'h0001;
      gap_d = conv_done_i ? 32'h0000_0000 : gap_q + 32'h0000_0001;
      arm_d = conv_done_i | (arm_q & ~conv_start_o);
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cfg_q <= 5'h00;
         low_q <= 16'h0000;
         gap_q <= 32'h0000_0000;
         arm_q <= 1'b0;
      end
      else
      begin
         cfg_q <= cfg_d;
         low_q <= low_d;
         gap_q <= gap_d;
         arm_q <= arm_d;
      end
   end

   sequence s_cmp_steady;
      (cfg_q[4:3] == 2'b01 && !cfg_q[2] && $stable(cfg_q)) [*3];
   endsequence
   sequence s_cmd_unrouted;
      $rose(reset_cmd_i) && cfg_q[4:3] != 2'b10;
   endsequence

   a_pin_off_idle: assert property (cfg_q[4] == cfg_q[3]
      |=> shared_alert_pin_oe_n_o) else $error("pin driven unrouted");
   a_os_pin_driven: assert property (cfg_q[4:3] == 2'b01
      |=> !shared_alert_pin_oe_n_o) else $error("os pin not driven");
   a_rst_pin_driven: assert property (cfg_q[4:3] == 2'b10
      |=> !shared_alert_pin_oe_n_o) else $error("reset pin not driven");
   a_pulse_length: assert property (
      $rose(shared_alert_pin_o) && cfg_q[4:3] == 2'b10
      |-> low_q == RST_PULSE_CYCLES && reset_cmd_done_o)
      else $error("reset pulse length or done wrong");
   a_cmd_unrouted: assert property (s_cmd_unrouted
      |=> reset_cmd_done_o) else $error("no done when unrouted");
   a_status_mirror: assert property (
      reg_rd_i && reg_addr_i == 8'h06 |=> reg_rdata_o[0] ==
      ($past(cfg_q[4:3]) == 2'b01 ? $past(shared_alert_pin_o) : 1'b1))
      else $error("status bit wrong");
   a_os_comparator: assert property (s_cmp_steady
      |-> shared_alert_pin_o == ~(cfg_q[1] ^ $past(overtemp_hit_i, 2)))
      else $error("comparator pin wrong");
   a_delay_length: assert property (
      conv_start_o && arm_q && !cfg_q[0]
      |-> gap_q >= (8 * rate_count_i + 6) * MON_UNIT_CYCLES
      && gap_q <= (8 * rate_count_i + 6) * MON_UNIT_CYCLES + 4)
      else $error("monitoring delay wrong");
   a_conv_continuous: assert property (conv_done_i && cfg_q[0]
      |-> ##[2:3] conv_start_o) else $error("no restart");
endmodule

bind mpr_top mpr_top_properties #(
   .MON_UNIT_CYCLES  (MON_UNIT_CYCLES),
   .RST_PULSE_CYCLES (RST_PULSE_CYCLES)
) i_mpr_top_properties (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
   .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .overtemp_hit_i,
   .rate_count_i, .conv_done_i, .conv_start_o, .reset_cmd_i,
   .reset_cmd_done_o, .shared_alert_pin_o, .shared_alert_pin_oe_n_o);

// file: tb/mpr_top_test.sv
// Purpose: self-checking bench of mpr_top
// Assumes: short monitor unit and reset pulse parameters
// Notes:   inputs change at the falling edge
`timescale 1ns/1ps
module mpr_top_test
   import mpr_pkg::*;
;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;}
      mpr_row_t;
   localparam int D = (8 * 1 + 6) * 4;
   mpr_row_t   rows [7] = '{24'h05_0000, 24'h05_FFFF, 24'h06_0E0F,
      24'h06_A0A1, 24'h07_0101, 24'h07_0000, 24'h08_FF00};
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic       reg_wr_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic       reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [1:0] tach_input_i = 2'b00;
   logic [1:0] fan_limit_hit_i = 2'b00;
   logic [1:0] fan_count_pulse_o;
   logic [1:0] fan_event_o;
   logic       overtemp_hit_i = 1'b0;
   logic       temp_wr_i = 1'b0;
   logic [3:0] temp_frac_i = 4'h0;
   logic       temp_hi_res_o;
   logic [7:0] rate_count_i = 8'h01;
   logic       conv_done_i = 1'b0;
   logic       conv_start_o;
   logic       reset_cmd_i = 1'b0;
   logic       reset_cmd_done_o;
   logic       shared_alert_pin_o;
   logic       shared_alert_pin_oe_n_o;
   logic [7:0] v;
   int         n, pc0, pc1;
   int         failures = 0;
   int         checks = 0;

   mpr_top #(.MON_UNIT_CYCLES(4), .RST_PULSE_CYCLES(3)) i_mpr_top (
      .clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
      .reg_rdata_o, .tach_input_i, .fan_limit_hit_i, .fan_count_pulse_o,
      .fan_event_o, .overtemp_hit_i, .temp_wr_i, .temp_frac_i,
      .temp_hi_res_o, .rate_count_i, .conv_done_i, .conv_start_o,
      .reset_cmd_i, .reset_cmd_done_o, .shared_alert_pin_o,
      .shared_alert_pin_oe_n_o);

   always #4 clk_i = ~clk_i;

   always @(negedge clk_i)
   begin
      pc0 += fan_count_pulse_o[0];
      pc1 += fan_count_pulse_o[1];
   end

   task automatic final_report;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      cyc(1);
      reg_wr_i = 1'b0;
   endtask

   // rdata stands until the next read, so sampling late is safe
   task automatic rd(input logic [7:0] a);
      cyc(1);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      cyc(1);
      reg_rd_i = 1'b0;
      cyc(1);
      v = reg_rdata_o;
   endtask

   task automatic chk_rst;
      rd(8'h05);
      chk(v, 8'h14);
      rd(8'h06);
      chk(v, 8'h01);
      rd(8'h07);
      chk(v, 8'h40);
      chk(8'(shared_alert_pin_oe_n_o), 8'h01);
   endtask

   task automatic tw(input logic [3:0] f);
      temp_frac_i = f;
      temp_wr_i = 1'b1;
      cyc(1);
      temp_wr_i = 1'b0;
   endtask

   // done is dropped after one cycle, then start is awaited
   task automatic tmr;
      conv_done_i = 1'b1;
      n = 0;
      while (n < 2000 && !(n > 0 && conv_start_o))
      begin
         cyc(1);
         conv_done_i = 1'b0;
         n++;
      end
   endtask

   initial
   begin
      repeat (20000) @(posedge clk_i);
      failures++;
      final_report();
   end

   initial
   begin
      cyc(6);
      rst_i = 1'b0;
      chk_rst();
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         chk(v, rows[i].e);
      end
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h05, 8'h03);
         wr(8'h05, {2'b00, c[1:0], c[1:0], 2'b00});
         cyc(4);
         pc0 = 0;
         pc1 = 0;
         repeat (16)
         begin
            tach_input_i = 2'b11;
            cyc(2);
            tach_input_i = 2'b00;
            cyc(2);
         end
         cyc(6);
         chk(8'(pc0), 8'h10 >> c);
         chk(8'(pc1), 8'h10 >> c);
      end
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h05, {2'b00, c[1:0], c[1:0], 2'b11});
         tach_input_i = 2'b11;
         cyc(5);
         chk(8'(fan_event_o), c == 1 ? 8'h00 : 8'h03);
         tach_input_i = 2'b00;
         cyc(5);
         chk(8'(fan_event_o), c == 1 ? 8'h03 : 8'h00);
      end
      wr(8'h05, 8'h00);
      fan_limit_hit_i = 2'b10;
      cyc(2);
      chk(8'(fan_event_o), 8'h02);
      fan_limit_hit_i = 2'b01;
      cyc(2);
      chk(8'(fan_event_o), 8'h01);
      fan_limit_hit_i = 2'b00;
      wr(8'h05, 8'h40);
      wr(8'h06, 8'h02);
      overtemp_hit_i = 1'b1;
      cyc(3);
      chk(8'({shared_alert_pin_oe_n_o, shared_alert_pin_o}), 8'h01);
      rd(8'h06);
      chk(v & 8'h0F, 8'h03);
      overtemp_hit_i = 1'b0;
      cyc(3);
      chk(8'(shared_alert_pin_o), 8'h00);
      wr(8'h06, 8'h00);
      cyc(2);
      chk(8'(shared_alert_pin_o), 8'h01);
      wr(8'h06, 8'h06);
      overtemp_hit_i = 1'b1;
      cyc(1);
      overtemp_hit_i = 1'b0;
      cyc(4);
      chk(8'(shared_alert_pin_o), 8'h01);
      rd(8'h06);
      cyc(2);
      chk(8'(shared_alert_pin_o), 8'h00);
      wr(8'h06, 8'h08);
      tw(4'hA);
      chk(8'(temp_hi_res_o), 8'h01);
      rd(8'h06);
      chk(v & 8'hF8, 8'hA8);
      wr(8'h06, 8'h00);
      tw(4'hB);
      rd(8'h06);
      chk(v & 8'hF8, 8'h80);
      wr(8'h05, 8'h00);
      wr(8'h05, 8'h80);
      reset_cmd_i = 1'b1;
      n = 0;
      for (int i = 0; i < 50 && !reset_cmd_done_o; i++)
      begin
         cyc(1);
         n += 32'(!shared_alert_pin_o);
      end
      reset_cmd_i = 1'b0;
      chk(8'(n), 8'h03);
      chk(8'(reset_cmd_done_o), 8'h01);
      wr(8'h05, 8'hC0);
      cyc(1);
      reset_cmd_i = 1'b1;
      cyc(1);
      chk(8'({reset_cmd_done_o, shared_alert_pin_oe_n_o}), 8'h03);
      reset_cmd_i = 1'b0;
      tmr();
      chk(8'(n >= D && n <= D + 4), 8'h01);
      wr(8'h07, 8'h01);
      tmr();
      chk(8'(n >= 2 && n <= 3), 8'h01);
      rst_i = 1'b1;
      cyc(2);
      rst_i = 1'b0;
      chk_rst();
      final_report();
   end
endmodule
